//--- core/psrm_map.vh
// register offsets, field positions and reset values of the pad routing matrix
`ifndef PSRM_MAP_VH
`define PSRM_MAP_VH

// address window decode on addr[11:10]
`define PSRM_WIN_MISC 2'h0
`define PSRM_WIN_IN_ROUTE 2'h1
`define PSRM_WIN_OUT_ROUTE 2'h2
`define PSRM_WIN_PAD_CFG 2'h3

// misc window word indices (addr[9:2])
`define PSRM_OUT_DATA_LO 8'h00
`define PSRM_OUT_DATA_HI 8'h01
`define PSRM_EN_DATA_LO 8'h02
`define PSRM_EN_DATA_HI 8'h03
`define PSRM_LEVEL_LO 8'h04
`define PSRM_LEVEL_HI 8'h05
`define PSRM_LP_ROUTE_LO 8'h06
`define PSRM_LP_ROUTE_HI 8'h07

// input_route_config fields
`define PSRM_IN_SEL_MSB 5
`define PSRM_IN_INV_BIT 6
`define PSRM_IN_BYP_BIT 7
`define PSRM_IN_CONST0 6'h30
`define PSRM_IN_CONST1 6'h38
`define PSRM_IN_RST 8'h30

// output_route_config fields
`define PSRM_OUT_SEL_MSB 8
`define PSRM_OUT_INV_BIT 9
`define PSRM_OUT_OES_BIT 10
`define PSRM_OUT_OD_BIT 11
`define PSRM_OUT_SW_SEL 9'h100
`define PSRM_OUT_RST 12'h500

// pad config fields
`define PSRM_PAD_FUNC_MSB 2
`define PSRM_PAD_IE_BIT 3
`define PSRM_PAD_PU_BIT 4
`define PSRM_PAD_PD_BIT 5
`define PSRM_PAD_DRV_LSB 6
`define PSRM_PAD_DRV_MSB 7
`define PSRM_FUNC_GENERAL 3'h2
`define PSRM_FUNC_DIRECT1 3'h1
`define PSRM_FUNC_DIRECT0 3'h0
`define PSRM_PAD_RST 8'h82

`endif

//--- core/psrm_top.v
// pad signal routing matrix: input matrix, output matrix, per-pad function mux
// How it works
// RL1: every one of 256 peripheral inputs selects any pad 0..39 as source
// RL2: every pad output takes one peripheral output chosen by its output selector
// RL3: pads 34..39 are input only; their output enable stays low
// RL4: input selector 0x30 gives constant zero, 0x38 gives constant one
// RL5: per-input invert bit flips the routed value
// RL6: per-pad output invert bit flips the routed output value
// RL7: one pad may feed any number of peripheral inputs
// RL8: one peripheral output may drive several pads at once
// RL9: output selector 0x100 drives the pad from software output data
// RL10: level register shows every pad level, independent of routing
// RL11: enable source bit set uses enable data; clear uses peripheral enable
// RL12: software disables input-only pads via enable source one, enable data zero
// RL13: open-drain bit makes the pad drive low only, released for high
// RL14: per-pad function select picks general matrix or a direct function
// RL15: software sets general function, input enable and pulls for matrix input
// RL16: per-pad drive-strength field is passed to the pad driver
// RL17: input bypass bit takes the pad straight, else the matrix source
// RL18: low-power pads hold output in deep sleep and feed wake-up inputs
// RL19: a pad with input enable clear reads as zero everywhere
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "psrm_map.vh"

module psrm_top #(
   parameter NUM_PADS = 40,
   parameter NUM_OUT_PADS = 34,
   parameter NUM_SIGS = 256,
   parameter [39:0] LP_PAD_MASK = 40'hFF_0E00_F015
) (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   // register port
   input wire [11:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [31:0] O_RDATA,
   // peripheral side
   input wire [255:0] I_PERIPH_OUT,
   input wire [255:0] I_PERIPH_OE,
   output reg [255:0] O_PERIPH_IN,
   // direct functions, two per pad
   input wire [79:0] I_DIRECT_OUT,
   input wire [79:0] I_DIRECT_OE,
   output reg [39:0] O_DIRECT_IN,
   // low-power domain
   input wire I_DEEP_SLEEP,
   input wire [39:0] I_LP_OUT,
   input wire [39:0] I_LP_OE,
   output reg [39:0] O_LP_IN,
   // pads
   input wire [39:0] I_PAD_IN,
   output reg [39:0] O_PAD_OUT,
   output reg [39:0] O_PAD_OE,
   output reg [39:0] O_PAD_PU,
   output reg [39:0] O_PAD_PD,
   output reg [79:0] O_PAD_DRV
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration storage
   reg [7:0] in_cfg_reg [0:255];
   reg [11:0] out_cfg_reg [0:39];
   reg [7:0] pad_cfg_reg [0:39];
   reg [39:0] out_data_reg;
   reg [39:0] en_data_reg;
   reg [39:0] lp_route_reg;
   reg [39:0] pad_meta_reg;
   reg [39:0] pad_sync_reg;
   // loop index for clearing the configuration arrays in reset
   integer k;

   // address split: window in [11:10], word index in [9:2], byte bits ignored
   wire [1:0] win = I_ADDR[11:10];
   wire [7:0] widx = I_ADDR[9:2];
   // output and pad windows hold 40 entries; higher indices write and read nothing
   wire pad_idx_ok = (widx < NUM_PADS);

   ////////////////////////////////////////////////////////////////////////////
   // pad inputs pass two flip-flops before any logic reads them
   // only the second stage is read, so a metastable first stage never spreads
   always @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         pad_meta_reg <= 40'h00_0000_0000;
         pad_sync_reg <= 40'h00_0000_0000;
      end else begin
         pad_meta_reg <= I_PAD_IN;
         pad_sync_reg <= pad_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   always @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         for (k = 0; k < 256; k = k + 1) begin
            in_cfg_reg[k] <= `PSRM_IN_RST;
         end
         for (k = 0; k < 40; k = k + 1) begin
            out_cfg_reg[k] <= `PSRM_OUT_RST;
            pad_cfg_reg[k] <= `PSRM_PAD_RST;
         end
         out_data_reg <= 40'h00_0000_0000;
         en_data_reg <= 40'h00_0000_0000;
         lp_route_reg <= 40'h00_0000_0000;
      end else if (I_WR) begin
         case (win)
            `PSRM_WIN_IN_ROUTE: begin
               in_cfg_reg[widx] <= I_WDATA[7:0];
            end
            `PSRM_WIN_OUT_ROUTE: begin
               if (pad_idx_ok) begin
                  out_cfg_reg[widx[5:0]] <= I_WDATA[11:0];
               end
            end
            `PSRM_WIN_PAD_CFG: begin
               if (pad_idx_ok) begin
                  pad_cfg_reg[widx[5:0]] <= I_WDATA[7:0];
               end
            end
            default: begin
               case (widx)
                  `PSRM_OUT_DATA_LO: out_data_reg[31:0] <= I_WDATA;
                  `PSRM_OUT_DATA_HI: out_data_reg[39:32] <= I_WDATA[7:0];
                  `PSRM_EN_DATA_LO: en_data_reg[31:0] <= I_WDATA;
                  `PSRM_EN_DATA_HI: en_data_reg[39:32] <= I_WDATA[7:0];
                  // only pads with a low-power route can be taken over
                  `PSRM_LP_ROUTE_LO: lp_route_reg[31:0] <= I_WDATA & LP_PAD_MASK[31:0];
                  `PSRM_LP_ROUTE_HI: lp_route_reg[39:32] <= I_WDATA[7:0] & LP_PAD_MASK[39:32];
                  // level words are read only; writes to them and to holes are dropped
                  default: lp_route_reg <= lp_route_reg;
               endcase
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pad levels and function decode
   wire [39:0] pad_lvl;
   wire [39:0] pad_general;
   wire [39:0] pad_out_next;
   wire [39:0] pad_oe_next;
   wire [39:0] pad_pu_next;
   wire [39:0] pad_pd_next;
   wire [79:0] pad_drv_next;
   wire [39:0] direct_in_next;
   wire [39:0] lp_in_next;

   // the deep-sleep hold feeds the registered pad outputs back in, so the
   // pad keeps the last level it showed and not whatever the low-power
   // side happens to drive while the awake logic is stopped
   genvar p;
   generate
      for (p = 0; p < NUM_PADS; p = p + 1) begin : g_pad
         wire [7:0] pcfg = pad_cfg_reg[p];
         wire [11:0] ocfg = out_cfg_reg[p];
         wire [2:0] func = pcfg[`PSRM_PAD_FUNC_MSB:0];
         wire [8:0] osel = ocfg[`PSRM_OUT_SEL_MSB:0];
         wire sw_sel = (osel == `PSRM_OUT_SW_SEL);
         wire per_sel = ~osel[8];
         wire lp_taken = lp_route_reg[p];
         reg mx_val;
         reg mx_oe_sig;
         reg mx_oe;
         reg fn_val;
         reg fn_oe;
         reg fin_val;
         reg fin_oe;

         // disabled input reads as zero everywhere [RL19] [RL10]
         assign pad_lvl[p] = pad_sync_reg[p] & pcfg[`PSRM_PAD_IE_BIT];
         assign pad_general[p] = (func == `PSRM_FUNC_GENERAL);

         // matrix output, function mux, open drain and low-power override
         always @* begin
            // any pad may select any peripheral output, so sharing is free [RL2] [RL8]
            mx_val = 1'b0;
            mx_oe_sig = 1'b0;
            if (sw_sel) begin
               mx_val = out_data_reg[p]; // [RL9]
               mx_oe_sig = en_data_reg[p];
            end else if (per_sel) begin
               mx_val = I_PERIPH_OUT[osel[7:0]];
               mx_oe_sig = I_PERIPH_OE[osel[7:0]];
            end
            mx_val = mx_val ^ ocfg[`PSRM_OUT_INV_BIT]; // [RL6]
            // enable from enable data or from the peripheral [RL11] [RL12]
            mx_oe = ocfg[`PSRM_OUT_OES_BIT] ? en_data_reg[p] : mx_oe_sig;
            // open drain: drive only a low, release for a high [RL13]
            if (ocfg[`PSRM_OUT_OD_BIT]) begin
               mx_oe = mx_oe & ~mx_val;
               mx_val = 1'b0;
            end
            // general function or a direct function [RL14]
            case (func)
               `PSRM_FUNC_GENERAL: begin
                  fn_val = mx_val;
                  fn_oe = mx_oe;
               end
               `PSRM_FUNC_DIRECT0: begin
                  fn_val = I_DIRECT_OUT[2*p];
                  fn_oe = I_DIRECT_OE[2*p];
               end
               `PSRM_FUNC_DIRECT1: begin
                  fn_val = I_DIRECT_OUT[2*p+1];
                  fn_oe = I_DIRECT_OE[2*p+1];
               end
               default: begin
                  fn_val = 1'b0;
                  fn_oe = 1'b0;
               end
            endcase
            // low-power route: follow it awake, hold the pad in deep sleep [RL18]
            // the sleep flag comes from logic on this clock, so it is used directly
            if (lp_taken && I_DEEP_SLEEP) begin
               fin_val = O_PAD_OUT[p];
               fin_oe = O_PAD_OE[p];
            end else if (lp_taken) begin
               fin_val = I_LP_OUT[p];
               fin_oe = I_LP_OE[p];
            end else begin
               fin_val = fn_val;
               fin_oe = fn_oe;
            end
            // input-only pads never enable a driver [RL3]
            // this cut comes last so that no route, low-power included, can bypass it
            if (p >= NUM_OUT_PADS) begin
               fin_oe = 1'b0;
            end
         end

         assign pad_out_next[p] = fin_val;
         assign pad_oe_next[p] = fin_oe;
         assign pad_pu_next[p] = pcfg[`PSRM_PAD_PU_BIT];
         assign pad_pd_next[p] = pcfg[`PSRM_PAD_PD_BIT];
         // larger field value gives a stronger driver [RL16]
         assign pad_drv_next[2*p+1:2*p] = pcfg[`PSRM_PAD_DRV_MSB:`PSRM_PAD_DRV_LSB];
         // direct-function input path and wake-up level to the low-power domain
         assign direct_in_next[p] = pad_general[p] ? 1'b0 : pad_lvl[p];
         assign lp_in_next[p] = lp_taken & pad_lvl[p]; // [RL18]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // input matrix; pads outside 0..39 and unused selectors read zero
   // the matrix path only sees pads in the general function, while the
   // bypass path takes the enabled pad level whatever the function is
   wire [63:0] gen_lvl = {24'h00_0000, pad_lvl & pad_general};
   wire [63:0] raw_lvl = {24'h00_0000, pad_lvl};
   wire [255:0] periph_in_next;

   genvar s;
   generate
      for (s = 0; s < NUM_SIGS; s = s + 1) begin : g_sig
         wire [7:0] icfg = in_cfg_reg[s];
         wire [5:0] isel = icfg[`PSRM_IN_SEL_MSB:0];
         reg mval;
         reg ival;

         always @* begin
            // every input indexes the pad vector, so one pad feeds many [RL1] [RL7]
            if (isel == `PSRM_IN_CONST0) begin
               mval = 1'b0; // [RL4]
            end else if (isel == `PSRM_IN_CONST1) begin
               mval = 1'b1; // [RL4]
            end else begin
               mval = gen_lvl[isel];
            end
            mval = mval ^ icfg[`PSRM_IN_INV_BIT]; // [RL5]
            // bypass takes the pad straight past the matrix [RL17]
            ival = icfg[`PSRM_IN_BYP_BIT] ? raw_lvl[isel] : mval;
         end

         assign periph_in_next[s] = ival;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // read data, valid in the cycle after the read strobe
   // reads have no side effects, so a read of any word is harmless
   reg [31:0] rdata_next;
   always @* begin
      rdata_next = 32'h0000_0000;
      case (win)
         `PSRM_WIN_IN_ROUTE: rdata_next = {24'h00_0000, in_cfg_reg[widx]};
         `PSRM_WIN_OUT_ROUTE: begin
            if (pad_idx_ok) begin
               rdata_next = {20'h0_0000, out_cfg_reg[widx[5:0]]};
            end
         end
         `PSRM_WIN_PAD_CFG: begin
            if (pad_idx_ok) begin
               rdata_next = {24'h00_0000, pad_cfg_reg[widx[5:0]]};
            end
         end
         default: begin
            case (widx)
               `PSRM_OUT_DATA_LO: rdata_next = out_data_reg[31:0];
               `PSRM_OUT_DATA_HI: rdata_next = {24'h00_0000, out_data_reg[39:32]};
               `PSRM_EN_DATA_LO: rdata_next = en_data_reg[31:0];
               `PSRM_EN_DATA_HI: rdata_next = {24'h00_0000, en_data_reg[39:32]};
               `PSRM_LEVEL_LO: rdata_next = pad_lvl[31:0]; // [RL10]
               `PSRM_LEVEL_HI: rdata_next = {24'h00_0000, pad_lvl[39:32]}; // [RL10]
               `PSRM_LP_ROUTE_LO: rdata_next = lp_route_reg[31:0];
               `PSRM_LP_ROUTE_HI: rdata_next = {24'h00_0000, lp_route_reg[39:32]};
               default: rdata_next = 32'h0000_0000;
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // every output comes from a flip-flop
   always @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         O_RDATA <= 32'h0000_0000;
         O_PERIPH_IN <= {256{1'b0}};
         O_DIRECT_IN <= 40'h00_0000_0000;
         O_LP_IN <= 40'h00_0000_0000;
         O_PAD_OUT <= 40'h00_0000_0000;
         O_PAD_OE <= 40'h00_0000_0000;
         O_PAD_PU <= 40'h00_0000_0000;
         O_PAD_PD <= 40'h00_0000_0000;
         // every pad starts at the middle drive step, as its pad config does
         O_PAD_DRV <= 80'hAAAA_AAAA_AAAA_AAAA_AAAA;
      end else begin
         O_RDATA <= I_RD ? rdata_next : 32'h0000_0000;
         O_PERIPH_IN <= periph_in_next;
         O_DIRECT_IN <= direct_in_next;
         O_LP_IN <= lp_in_next;
         O_PAD_OUT <= pad_out_next;
         O_PAD_OE <= pad_oe_next;
         O_PAD_PU <= pad_pu_next;
         O_PAD_PD <= pad_pd_next;
         O_PAD_DRV <= pad_drv_next;
      end
   end

endmodule // psrm_top
`default_nettype wire

//--- dv/psrm_props.sv
// concurrent checks on the ports of the pad routing matrix
`timescale 1ns/1ps
`default_nettype none
module psrm_props (
   input wire I_CLK_SYS,
   input wire I_RST_N,
   input wire [11:0] I_ADDR,
   input wire [31:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   input wire [31:0] O_RDATA,
   input wire [255:0] O_PERIPH_IN,
   input wire [39:0] O_PAD_OE,
   input wire [79:0] O_PAD_DRV
);
   reg [7:0] last_idx;
   reg [31:0] last_wd;
   reg pad_cfg_seen;
   ////////////////////////////////////////////////////////////////
   // remember target and data of the latest write
   always @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         last_idx <= 8'h00;
         last_wd <= 32'h0;
         pad_cfg_seen <= 1'h0;
      end else if (I_WR) begin
         last_idx <= I_ADDR[9:2];
         last_wd <= I_WDATA;
         pad_cfg_seen <= pad_cfg_seen | (I_ADDR[11:10] == 2'h3);
      end
   end
   ////////////////////////////////////////////////////////////////
   property p_reset_drv;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      $rose(I_RST_N) |-> O_PAD_DRV == {40{2'h2}} && O_PAD_OE == 40'h0;
   endproperty
   a_reset_drv: assert property (p_reset_drv)
      else $error("pad drive or enable not at reset value");
   property p_reset_in;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      $rose(I_RST_N) |-> O_PERIPH_IN == 256'h0;
   endproperty
   a_reset_in: assert property (p_reset_in)
      else $error("peripheral inputs not constant zero after reset");
   property p_rdata_idle;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      !$past(I_RD) |-> O_RDATA == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");
   property p_misc_hole;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      I_RD && I_ADDR[11:10] == 2'h0 && I_ADDR[9:2] > 8'h07 |=> O_RDATA == 32'h0;
   endproperty
   a_misc_hole: assert property (p_misc_hole)
      else $error("unmapped word read not zero");
   property p_in_only;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      O_PAD_OE[39:34] == 6'h00;
   endproperty
   a_in_only: assert property (p_in_only)
      else $error("input only pad drives");
   property p_drv_follow;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      I_WR && I_ADDR[11:10] == 2'h3 && I_ADDR[9:2] < 8'h28 ##1 !I_WR
         |=> O_PAD_DRV[{last_idx, 1'h0} +: 2] == last_wd[7:6];
   endproperty
   a_drv_follow: assert property (p_drv_follow)
      else $error("drive strength does not follow pad config");
   property p_const_in;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      I_WR && I_ADDR[11:10] == 2'h1 && (I_WDATA[7:0] == 8'h30 || I_WDATA[7:0] == 8'h38)
         ##1 !I_WR |=> O_PERIPH_IN[last_idx] == last_wd[3];
   endproperty
   a_const_in: assert property (p_const_in)
      else $error("constant input source wrong");
   property p_level_gated;
      @(posedge I_CLK_SYS) disable iff (!I_RST_N)
      I_RD && I_ADDR == 12'h010 && !pad_cfg_seen |=> O_RDATA == 32'h0;
   endproperty
   a_level_gated: assert property (p_level_gated)
      else $error("level shows pad with input disabled");
endmodule // psrm_props
bind psrm_top psrm_props psrm_props_inst (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
   .O_PERIPH_IN(O_PERIPH_IN), .O_PAD_OE(O_PAD_OE), .O_PAD_DRV(O_PAD_DRV));
`default_nettype wire

//--- dv/psrm_periph_model.sv
// peripheral side model: drives output values and enables from a pattern
`timescale 1ns/1ps
`default_nettype none
module psrm_periph_model (
   input wire logic i_clk,
   input wire logic [7:0] i_pattern,
   output logic [255:0] o_periph_out,
   output logic [255:0] o_periph_oe
);
   ////////////////////////////////////////////////////////////////
   // registered drive, enable is the inverse of the value
   always @(posedge i_clk) begin
      o_periph_out <= {32{i_pattern}};
      o_periph_oe <= {32{~i_pattern}};
   end
endmodule // psrm_periph_model
`default_nettype wire

//--- dv/psrm_bench.sv
// self-checking bench for the pad routing matrix
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end
module psrm_bench;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [39:0] pad_in = 40'hFF_0000_0180;
   logic [79:0] dir_out = 80'h1_0000;
   logic [39:0] lp_out = 40'h00_0000_0000;
   logic [39:0] lp_oe = 40'h00_0000_0000;
   logic sleep = 1'h0;
   logic [7:0] pattern = 8'h00;
   logic [31:0] rdata, d;
   logic [255:0] p_out, p_oe, p_in;
   logic [39:0] direct_in, pad_out, pad_oe, pad_pu, pad_pd, lp_in;
   logic [79:0] pad_drv;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int i;
   always #5 clk = ~clk;
   psrm_periph_model psrm_periph_model_inst (.i_clk(clk), .i_pattern(pattern),
      .o_periph_out(p_out), .o_periph_oe(p_oe));
   psrm_top psrm_top_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PERIPH_OUT(p_out), .I_PERIPH_OE(p_oe),
      .O_PERIPH_IN(p_in), .I_DIRECT_OUT(dir_out), .I_DIRECT_OE(dir_out),
      .O_DIRECT_IN(direct_in), .I_DEEP_SLEEP(sleep), .I_LP_OUT(lp_out), .I_LP_OE(lp_oe),
      .O_LP_IN(lp_in), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe),
      .O_PAD_PU(pad_pu), .O_PAD_PD(pad_pd), .O_PAD_DRV(pad_drv));
   ////////////////////////////////////////////////////////////////
   // register port access
   task wr_reg(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task rd_reg(input logic [11:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdata;
   endtask
   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         give_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      rd_reg(12'hC00);
      `CHK("pad cfg", 32'h82, d);
      rd_reg(12'h800);
      `CHK("out cfg", 32'h500, d);
      rd_reg(12'h010);
      `CHK("level ie off", 32'h0, d);
      rd_reg(12'h020);
      `CHK("hole", 32'h0, d);
      for (i = 0; i < 4; i++) begin
         wr_reg(12'h400 + 12'(4 * i), 32'h30 | (i[0] << 3) | (i[1] << 6));
         settle(1);
         `CHK("const", i[0] ^ i[1], p_in[i]);
      end
      wr_reg(12'hC1C, 32'h0A);
      wr_reg(12'h81C, 32'h500);
      wr_reg(12'hC20, 32'h08);
      wr_reg(12'hC0C, 32'hC2);
      wr_reg(12'h428, 32'h07);
      wr_reg(12'h42C, 32'h47);
      wr_reg(12'h430, 32'h88);
      wr_reg(12'h434, 32'h08);
      settle(3);
      `CHK("in10", 1'h1, p_in[10]);
      `CHK("in11", 1'h0, p_in[11]);
      `CHK("bypass", 1'h1, p_in[12]);
      `CHK("matrix off", 1'h0, p_in[13]);
      `CHK("direct", 1'h1, direct_in[8]);
      `CHK("drv", 4'h3, {pad_drv[15:14], pad_drv[7:6]});
      `CHK("direct out", 2'h3, {pad_out[8], pad_oe[8]});
      `CHK("input pad oe", 1'h0, pad_oe[7]);
      rd_reg(12'h010);
      `CHK("level", 32'h180, d);
      wr_reg(12'hC1C, 32'h12);
      settle(3);
      `CHK("ie off", 1'h0, p_in[10]);
      `CHK("pulls", 2'h2, {pad_pu[7], pad_pd[7]});
      wr_reg(12'h814, 32'h003);
      wr_reg(12'h818, 32'h203);
      for (i = 0; i < 2; i++) begin
         pattern <= i[0] ? 8'h08 : 8'h00;
         settle(2);
         `CHK("pad5", i[0], pad_out[5]);
         `CHK("pad6", ~i[0], pad_out[6]);
         `CHK("pad5 oe", ~i[0], pad_oe[5]);
      end
      wr_reg(12'h000, 32'h10);
      wr_reg(12'h008, 32'h10);
      settle(1);
      `CHK("sw out", 2'h3, {pad_out[4], pad_oe[4]});
      wr_reg(12'h810, 32'hD00);
      settle(1);
      `CHK("od high", 1'h0, pad_oe[4]);
      wr_reg(12'h000, 32'h0);
      settle(1);
      `CHK("od low", 2'h1, {pad_out[4], pad_oe[4]});
      wr_reg(12'h00C, 32'hFF);
      settle(1);
      `CHK("in only", 8'h03, pad_oe[39:32]);
      wr_reg(12'h018, 32'hFFFF_FFFF);
      rd_reg(12'h018);
      `CHK("lp mask", 32'h0E00_F015, d);
      wr_reg(12'hC80, 32'h0A);
      lp_out <= 40'h01_0000_0000;
      lp_oe <= 40'h01_0000_0000;
      wr_reg(12'h01C, 32'h01);
      settle(3);
      `CHK("lp drive", 2'h3, {pad_out[32], pad_oe[32]});
      `CHK("lp wake", 1'h1, lp_in[32]);
      @(posedge clk);
      sleep <= 1'h1;
      lp_out <= 40'h00_0000_0000;
      settle(2);
      `CHK("lp hold", 2'h3, {pad_out[32], pad_oe[32]});
      give_verdict;
   end
endmodule // psrm_bench
`default_nettype wire
